// [verilog/fcel_pkg.sv]
// Constants, field layouts and types shared by the fault unit files
package fcel_pkg;

  // Register byte offsets on the APB window
  localparam logic [7:0] OFF_HARD  = 8'h00;
  localparam logic [7:0] OFF_PROT  = 8'h04;
  localparam logic [7:0] OFF_BUS   = 8'h08;
  localparam logic [7:0] OFF_USAGE = 8'h0C;
  localparam logic [7:0] OFF_PADDR = 8'h10;
  localparam logic [7:0] OFF_BADDR = 8'h14;
  localparam logic [7:0] OFF_PRI   = 8'h18;
  localparam logic [7:0] OFF_CTRL  = 8'h1C;
  localparam logic [7:0] OFF_STAT  = 8'h20;

  // Cause flag positions inside the 16-bit cause registers
  localparam logic [3:0] HB_VECTOR_READ_ERROR_FLAG    = 4'h0;
  localparam logic [3:0] HB_ESC     = 4'h1;
  localparam logic [3:0] PB_FETCH   = 4'h0;
  localparam logic [3:0] PB_DATA    = 4'h1;
  localparam logic [3:0] PB_POP     = 4'h3;
  localparam logic [3:0] PB_PUSH    = 4'h4;
  localparam logic [3:0] BB_PREF    = 4'h0;
  localparam logic [3:0] BB_EXACT   = 4'h1;
  localparam logic [3:0] BB_INEXACT = 4'h2;
  localparam logic [3:0] BB_POP     = 4'h3;
  localparam logic [3:0] BB_PUSH    = 4'h4;
  localparam logic [3:0] UB_BAD_OPCODE_FLAG   = 4'h0;
  localparam logic [3:0] UB_STATE   = 4'h1;
  localparam logic [3:0] UB_RET     = 4'h2;
  localparam logic [3:0] UB_COPROC  = 4'h3;
  localparam logic [3:0] UB_MISALIGNED_ACCESS_FLAG = 4'h8;
  localparam logic [3:0] UB_ZERO_DIVISOR_FLAG    = 4'h9;
  localparam logic [3:0] AB_VALID   = 4'h7;

  // Status register fields, control fields and reset values
  localparam int         ST_LOCK  = 0;
  localparam int         ST_LNMI  = 1;
  localparam int         ST_PEND  = 8;
  localparam int         CT_MEM   = 0;
  localparam int         CT_BUS   = 1;
  localparam int         CT_USAGE = 2;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [23:0] PRI_RST  = 24'h000000;

  // Exception numbers of the entries the unit arbitrates
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_NMI   = 8'h02;
  localparam logic [7:0] EXC_HARD  = 8'h03;
  localparam logic [7:0] EXC_MEM   = 8'h04;
  localparam logic [7:0] EXC_BUS   = 8'h05;
  localparam logic [7:0] EXC_USAGE = 8'h06;
  localparam int         N_EXC     = 5;

  typedef enum logic [4:0] {
    FC_NONE      = 5'h00, FC_VEC_RD    = 5'h01, FC_MPU_FETCH = 5'h02,
    FC_XN_FETCH  = 5'h03, FC_MPU_DATA  = 5'h04, FC_MPU_PUSH  = 5'h05,
    FC_MPU_POP   = 5'h06, FC_BUS_PUSH  = 5'h07, FC_BUS_POP   = 5'h08,
    FC_BUS_PREF  = 5'h09, FC_BUS_EXACT = 5'h0A, FC_BUS_INEX  = 5'h0B,
    FC_COPROC    = 5'h0C, FC_BAD_OPCODE_FLAG     = 5'h0D, FC_BAD_ISA   = 5'h0E,
    FC_BAD_CONT  = 5'h0F, FC_BAD_BRAN  = 5'h10, FC_BAD_RET   = 5'h11,
    FC_MISALIGNED_ACCESS_FLAG   = 5'h12, FC_ZERO_DIVISOR_FLAG      = 5'h13
  } fcel_cause_t;

  typedef enum logic [1:0] {
    FT_HARD = 2'h0, FT_MEM = 2'h1, FT_BUS = 2'h2, FT_USAGE = 2'h3
  } fcel_ftype_t;

  typedef enum logic [1:0] {
    LK_RUN = 2'h0, LK_HF = 2'h1, LK_NMI = 2'h2
  } fcel_lock_t;

endpackage

// [verilog/fcel_classify.sv]
// Sorts a detected error into its fault type and cause flag position
`timescale 1ns/100ps
module fcel_classify import fcel_pkg::*; (
  input  fcel_cause_t cause,
  output fcel_ftype_t ftype,
  output logic [3:0]  bitn,
  output logic        has_addr
);

  always_comb begin
    ftype    = FT_HARD;
    bitn     = HB_VECTOR_READ_ERROR_FLAG;
    has_addr = 1'b0;
    unique case (cause)
      FC_VEC_RD:    begin ftype = FT_HARD;  bitn = HB_VECTOR_READ_ERROR_FLAG;    end
      // No-execute fetches fault even with protection switched off
      FC_MPU_FETCH, FC_XN_FETCH:
                    begin ftype = FT_MEM;   bitn = PB_FETCH;   end
      FC_MPU_DATA:  begin ftype = FT_MEM;   bitn = PB_DATA;  has_addr = 1'b1; end
      FC_MPU_PUSH:  begin ftype = FT_MEM;   bitn = PB_PUSH;    end
      FC_MPU_POP:   begin ftype = FT_MEM;   bitn = PB_POP;     end
      FC_BUS_PUSH:  begin ftype = FT_BUS;   bitn = BB_PUSH;    end
      FC_BUS_POP:   begin ftype = FT_BUS;   bitn = BB_POP;     end
      FC_BUS_PREF:  begin ftype = FT_BUS;   bitn = BB_PREF;    end
      FC_BUS_EXACT: begin ftype = FT_BUS;   bitn = BB_EXACT; has_addr = 1'b1; end
      FC_BUS_INEX:  begin ftype = FT_BUS;   bitn = BB_INEXACT; end
      FC_COPROC:    begin ftype = FT_USAGE; bitn = UB_COPROC;  end
      FC_BAD_OPCODE_FLAG:     begin ftype = FT_USAGE; bitn = UB_BAD_OPCODE_FLAG;   end
      FC_BAD_ISA, FC_BAD_CONT, FC_BAD_BRAN:
                    begin ftype = FT_USAGE; bitn = UB_STATE;   end
      FC_BAD_RET:   begin ftype = FT_USAGE; bitn = UB_RET;     end
      FC_MISALIGNED_ACCESS_FLAG:   begin ftype = FT_USAGE; bitn = UB_MISALIGNED_ACCESS_FLAG; end
      FC_ZERO_DIVISOR_FLAG:      begin ftype = FT_USAGE; bitn = UB_ZERO_DIVISOR_FLAG;    end
      default:      begin ftype = FT_HARD;  bitn = HB_VECTOR_READ_ERROR_FLAG;    end
    endcase
  end

endmodule

// [verilog/fcel_arbiter.sv]
// Picks the pending entry to take next and checks it may preempt
`timescale 1ns/100ps
module fcel_arbiter import fcel_pkg::*; #(
  parameter int N  = 5,
  parameter int EW = 10
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [N-1:0]  pend,
  input  wire logic [N*EW-1:0] pri,
  input  wire logic [EW-1:0] cur,
  output logic               win,
  output logic [2:0]         idx
);

  logic [EW-1:0] best;
  logic          any;

  // Walking down with <= leaves the lowest index on a priority tie
  always_comb begin
    best = '1;
    any  = 1'b0;
    idx  = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i] && (!any || pri[i*EW +: EW] <= best)) begin
        best = pri[i*EW +: EW];
        idx  = 3'(i);
        any  = 1'b1;
      end
    end
    win = any && (best < cur);
  end

  property p_no_equal_preempt;
    @(posedge pclk) disable iff (!presetn)
      win |-> (pri[idx*EW +: EW] < cur) && pend[idx];
  endproperty
  a_no_equal_preempt: assert property (p_no_equal_preempt)
    else $error("entry taken without strictly higher priority");

endmodule

// [verilog/fcel_fault_unit.sv]
// Fault classification, escalation, lockup and APB register file
// Operation
// - vector read bus error gives hard fault
// - escalation sets escalated flag
// - fetch violation or no-execute gives protection fault
// - data access violation gives protection fault
// - push and pop violations set separate flags
// - push and pop bus errors set separate flags
// - prefetch bus error sets its flag
// - data bus error exact or inexact flag
// - each usage fault cause has own flag, except bad instruction set, continuation and branch share one
// - bad instruction set or continuation return
// - no-execute fetch and bad branch fault
// - configurable priorities and per-handler enables
// - fault in same kind handler escalates
// - fault not above current priority escalates
// - disabled handler fault escalates
// - bus push error entering bus handler stays
// - hard fault fixed just below NMI
// - capture address for data protection and exact bus faults
// - hard fault in NMI or hard handler locks
// - lockup left only by reset or NMI
// - lockup from NMI handler needs reset
// - ties go to lowest number, no preemption
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module fcel_fault_unit import fcel_pkg::*; #(
  parameter int PRI_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  fcel_cause_t      fault_cause,
  input  wire logic [31:0] fault_addr,
  input  wire logic        fault_addr_ok,
  input  wire logic        bus_entry_push,
  input  wire logic [7:0]  cur_exc,
  input  wire logic [PRI_W-1:0] exc_pri,
  input  wire logic        nmi_req,
  output logic             exc_take,
  output logic [7:0]       exc_num,
  output logic             lockup
);

  localparam int EW = PRI_W + 2;
  localparam logic [EW-1:0] NMI_EFF    = '0;
  localparam logic [EW-1:0] HARD_EFF   = EW'(1);
  localparam logic [EW-1:0] THREAD_EFF = '1;

  // Configurable levels sit below the two fixed ones
  function automatic logic [EW-1:0] eff(input logic [PRI_W-1:0] p);
    return EW'(p) + EW'(2);
  endfunction

  logic [15:0]      hard_cause_reg_r;
  logic [15:0]      protection_fault_cause_reg_r;
  logic [15:0]      bus_fault_cause_reg_r;
  logic [15:0]      usage_fault_cause_reg_r;
  logic [31:0]      protection_fault_addr_reg_r;
  logic [31:0]      bus_fault_addr_reg_r;
  logic [3*PRI_W-1:0] system_handler_priority_reg_r;
  logic [2:0]       system_handler_control_reg_r;
  logic [N_EXC-1:0] pend_r;
  logic [N_EXC-1:0] pend_nxt;
  fcel_lock_t       lock_r;
  logic             exc_take_r;
  logic [7:0]       exc_num_r;
  logic [31:0]      prdata_r;

  fcel_ftype_t      ftype;
  logic [3:0]       bitn;
  logic             has_addr;
  logic             ev;
  logic             cfg;
  logic             t_en;
  logic [PRI_W-1:0] t_pri;
  logic [EW-1:0]    cur_eff;
  logic             no_esc;
  logic             esc;
  logic             hard_now;
  logic             lock_go;
  logic             wr;
  logic             hit;
  logic [15:0]      set_vec;
  logic             arb_win;
  logic [2:0]       arb_idx;
  logic             take_now;
  logic [31:0]      rd_mux;
  logic [N_EXC-1:0] type_bit;

  fcel_classify u_classify (
    .cause    (fault_cause),
    .ftype    (ftype),
    .bitn     (bitn),
    .has_addr (has_addr)
  );

  assign ev      = (fault_cause != FC_NONE);
  assign cfg     = (ftype != FT_HARD);
  assign set_vec = 16'h0001 << bitn;
  // Pending slots run NMI, hard, mem, bus, usage, so a type sits one above its code
  assign type_bit = N_EXC'(1) << (3'(ftype) + 3'h1);

  // Priority and enable of the configurable type hit by this event
  always_comb begin
    t_pri = system_handler_priority_reg_r[0 +: PRI_W];
    t_en  = system_handler_control_reg_r[CT_MEM];
    unique case (ftype)
      FT_BUS: begin
        t_pri = system_handler_priority_reg_r[PRI_W +: PRI_W];
        t_en  = system_handler_control_reg_r[CT_BUS];
      end
      FT_USAGE: begin
        t_pri = system_handler_priority_reg_r[2*PRI_W +: PRI_W];
        t_en  = system_handler_control_reg_r[CT_USAGE];
      end
      default: begin
        t_pri = system_handler_priority_reg_r[0 +: PRI_W];
        t_en  = system_handler_control_reg_r[CT_MEM];
      end
    endcase
  end

  always_comb begin
    case (cur_exc)
      EXC_NONE:  cur_eff = THREAD_EFF;
      EXC_NMI:   cur_eff = NMI_EFF;
      EXC_HARD:  cur_eff = HARD_EFF;
      EXC_MEM:   cur_eff = eff(system_handler_priority_reg_r[0 +: PRI_W]);
      EXC_BUS:   cur_eff = eff(system_handler_priority_reg_r[PRI_W +: PRI_W]);
      EXC_USAGE: cur_eff = eff(system_handler_priority_reg_r[2*PRI_W +: PRI_W]);
      default:   cur_eff = eff(exc_pri);
    endcase
  end

  // A same-kind fault inside its own handler has equal priority,
  // so the >= test also covers the self-fault case
  assign no_esc   = (fault_cause == FC_BUS_PUSH) && bus_entry_push;
  assign esc      = ev && cfg && !no_esc
                    && (!t_en || eff(t_pri) >= cur_eff);
  assign hard_now = ev && (!cfg || esc);
  assign lock_go  = hard_now && (lock_r == LK_RUN)
                    && (cur_exc == EXC_NMI || cur_exc == EXC_HARD);

  // APB: zero wait states, read data latched in the setup cycle
  assign wr = psel && penable && pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      OFF_HARD:  rd_mux = {16'h0000, hard_cause_reg_r};
      OFF_PROT:  rd_mux = {16'h0000, protection_fault_cause_reg_r};
      OFF_BUS:   rd_mux = {16'h0000, bus_fault_cause_reg_r};
      OFF_USAGE: rd_mux = {16'h0000, usage_fault_cause_reg_r};
      OFF_PADDR: rd_mux = protection_fault_addr_reg_r;
      OFF_BADDR: rd_mux = bus_fault_addr_reg_r;
      OFF_PRI:   rd_mux = 32'(system_handler_priority_reg_r);
      OFF_CTRL:  rd_mux = 32'(system_handler_control_reg_r);
      OFF_STAT: begin
        rd_mux[ST_LOCK]             = (lock_r != LK_RUN);
        rd_mux[ST_LNMI]             = (lock_r == LK_NMI);
        rd_mux[ST_PEND +: N_EXC]    = pend_r;
      end
      default:   hit = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_handler_priority_reg_r <= (3*PRI_W)'(PRI_RST);
      system_handler_control_reg_r  <= CTRL_RST;
    end else if (wr) begin
      if (paddr == OFF_PRI) begin
        system_handler_priority_reg_r <= pwdata[3*PRI_W-1:0];
      end
      if (paddr == OFF_CTRL) begin
        system_handler_control_reg_r <= pwdata[2:0];
      end
    end
  end

  // Cause flags: write one to clear, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_cause_reg_r <= 16'h0000;
    end else begin
      hard_cause_reg_r <= (hard_cause_reg_r
                           & ~((wr && paddr == OFF_HARD) ? pwdata[15:0] : 16'h0000))
                          | ((ev && !cfg) ? set_vec : 16'h0000)
                          | (esc ? (16'h0001 << HB_ESC) : 16'h0000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_fault_cause_reg_r <= 16'h0000;
      protection_fault_addr_reg_r  <= 32'h00000000;
    end else begin
      protection_fault_cause_reg_r <= (protection_fault_cause_reg_r
          & ~((wr && paddr == OFF_PROT) ? pwdata[15:0] : 16'h0000))
          | ((ev && ftype == FT_MEM) ? set_vec : 16'h0000)
          | ((ev && ftype == FT_MEM && has_addr && fault_addr_ok)
             ? (16'h0001 << AB_VALID) : 16'h0000);
      if (ev && ftype == FT_MEM && has_addr && fault_addr_ok) begin
        protection_fault_addr_reg_r <= fault_addr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_fault_cause_reg_r <= 16'h0000;
      bus_fault_addr_reg_r  <= 32'h00000000;
    end else begin
      bus_fault_cause_reg_r <= (bus_fault_cause_reg_r
          & ~((wr && paddr == OFF_BUS) ? pwdata[15:0] : 16'h0000))
          | ((ev && ftype == FT_BUS) ? set_vec : 16'h0000)
          | ((ev && ftype == FT_BUS && has_addr && fault_addr_ok)
             ? (16'h0001 << AB_VALID) : 16'h0000);
      if (ev && ftype == FT_BUS && has_addr && fault_addr_ok) begin
        bus_fault_addr_reg_r <= fault_addr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usage_fault_cause_reg_r <= 16'h0000;
    end else begin
      usage_fault_cause_reg_r <= (usage_fault_cause_reg_r
          & ~((wr && paddr == OFF_USAGE) ? pwdata[15:0] : 16'h0000))
          | ((ev && ftype == FT_USAGE) ? set_vec : 16'h0000);
    end
  end

  // Lockup: no entries are taken; an NMI frees only a hard-fault lockup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= LK_RUN;
    end else begin
      unique case (lock_r)
        LK_RUN: begin
          if (lock_go) begin
            lock_r <= (cur_exc == EXC_NMI) ? LK_NMI : LK_HF;
          end
        end
        LK_HF: begin
          if (nmi_req) begin
            lock_r <= LK_RUN;
          end
        end
        LK_NMI:  lock_r <= LK_NMI;
        default: lock_r <= LK_RUN;
      endcase
    end
  end

  fcel_arbiter #(.N(N_EXC), .EW(EW)) u_arbiter (
    .pclk    (pclk),
    .presetn (presetn),
    .pend    (pend_r),
    .pri     ({eff(system_handler_priority_reg_r[2*PRI_W +: PRI_W]),
                eff(system_handler_priority_reg_r[PRI_W +: PRI_W]),
                eff(system_handler_priority_reg_r[0 +: PRI_W]),
                HARD_EFF, NMI_EFF}),
    .cur     (cur_eff),
    .win     (arb_win),
    .idx     (arb_idx)
  );

  // One take per two cycles gives the pipeline time to update cur_exc
  assign take_now = arb_win && !exc_take_r && (lock_r == LK_RUN);

  always_comb begin
    pend_nxt = pend_r;
    if (take_now) begin
      pend_nxt[arb_idx] = 1'b0;
    end
    if (nmi_req) begin
      pend_nxt[0] = 1'b1;
    end
    if (hard_now && !lock_go && lock_r == LK_RUN) begin
      pend_nxt[1] = 1'b1;
    end
    if (ev && cfg && !esc && !no_esc) begin
      pend_nxt[3'(ftype) + 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r     <= '0;
      exc_take_r <= 1'b0;
      exc_num_r  <= EXC_NONE;
    end else begin
      pend_r     <= pend_nxt;
      exc_take_r <= take_now;
      if (take_now) begin
        exc_num_r <= EXC_NMI + 8'(arb_idx);
      end
    end
  end

  assign exc_take = exc_take_r;
  assign exc_num  = exc_num_r;
  assign lockup   = (lock_r != LK_RUN);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_locked_nmi;
    (lock_r == LK_NMI) ##0 nmi_req;
  endsequence

  property p_vector_read_error_flag;
    fault_cause == FC_VEC_RD |=> hard_cause_reg_r[HB_VECTOR_READ_ERROR_FLAG];
  endproperty
  a_vector_read_error_flag: assert property (p_vector_read_error_flag)
    else $error("vector read error flag not set");

  property p_esc;
    esc |=> hard_cause_reg_r[HB_ESC] && (pend_r[1] || lockup);
  endproperty
  a_esc: assert property (p_esc)
    else $error("escalation not recorded as hard fault");

  property p_fetch;
    fault_cause == FC_XN_FETCH |=> protection_fault_cause_reg_r[PB_FETCH];
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("no-execute fetch flag not set");

  property p_pop;
    fault_cause == FC_MPU_POP |=> protection_fault_cause_reg_r[PB_POP];
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop violation flag not set");

  property p_zero_divisor_flag;
    fault_cause == FC_ZERO_DIVISOR_FLAG |=> usage_fault_cause_reg_r[UB_ZERO_DIVISOR_FLAG];
  endproperty
  a_zero_divisor_flag: assert property (p_zero_divisor_flag)
    else $error("zero divisor flag not set");

  property p_disabled;
    ev && cfg && !no_esc && !t_en && ((pend_r & type_bit) == '0)
      |=> ((pend_r & $past(type_bit)) == '0) && hard_cause_reg_r[HB_ESC];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("fault with disabled handler not escalated");

  property p_bus_push;
    no_esc |=> !$rose(hard_cause_reg_r[HB_ESC]) && bus_fault_cause_reg_r[BB_PUSH];
  endproperty
  a_bus_push: assert property (p_bus_push)
    else $error("push error on bus handler entry escalated");

  property p_addr;
    ev && ftype == FT_BUS && has_addr && fault_addr_ok
      |=> bus_fault_addr_reg_r == $past(fault_addr);
  endproperty
  a_addr: assert property (p_addr)
    else $error("bus fault address not captured");

  property p_lock;
    lock_go |=> lockup ##1 !exc_take;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lockup not entered");

  property p_exit;
    lock_r == LK_HF && nmi_req |=> !lockup && pend_r[0];
  endproperty
  a_exit: assert property (p_exit)
    else $error("nmi did not leave lockup");

  property p_nmi_stays;
    s_locked_nmi |=> lockup [*3];
  endproperty
  a_nmi_stays: assert property (p_nmi_stays)
    else $error("nmi released lockup entered from nmi handler");

  property p_hold;
    hard_cause_reg_r[HB_VECTOR_READ_ERROR_FLAG] && !(wr && paddr == OFF_HARD)
      |=> hard_cause_reg_r[HB_VECTOR_READ_ERROR_FLAG];
  endproperty
  a_hold: assert property (p_hold)
    else $error("cause flag lost without clear");

endmodule

// [bench/fcel_core_model.sv]
// Behavioural pipeline, protection and bus side that reports fault events
`timescale 1ns/100ps
module fcel_core_model import fcel_pkg::*; (
  input  wire logic   pclk,
  output fcel_cause_t fault_cause,
  output logic [31:0] fault_addr,
  output logic        fault_addr_ok,
  output logic        bus_entry_push
);
  initial begin
    fault_cause = FC_NONE;
    fault_addr = 32'h0;
    fault_addr_ok = 1'b0;
    bus_entry_push = 1'b0;
  end
  // One-cycle event; the address bus shows junk once the event is gone
  task automatic fire(input fcel_cause_t c, input logic [31:0] a, input logic ok, bp);
    @(posedge pclk);
    fault_cause <= c;
    fault_addr <= a;
    fault_addr_ok <= ok;
    bus_entry_push <= bp;
    @(posedge pclk);
    fault_cause <= FC_NONE;
    fault_addr <= ~a;
    fault_addr_ok <= 1'b0;
    bus_entry_push <= 1'b0;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the fault unit
`timescale 1ns/100ps
module tb import fcel_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nmi_req;
  logic exc_take, lockup, fault_addr_ok, bus_entry_push, er;
  logic [7:0] paddr, cur_exc, exc_pri, exc_num;
  logic [31:0] pwdata, prdata, fault_addr, rd, a;
  fcel_cause_t fault_cause;
  int fails, compares, cyc, k;
  int exp_c[4];
  localparam fcel_cause_t CS[18] = '{FC_VEC_RD, FC_MPU_FETCH, FC_XN_FETCH, FC_MPU_DATA,
    FC_MPU_PUSH, FC_MPU_POP, FC_BUS_PUSH, FC_BUS_POP, FC_BUS_PREF, FC_BUS_EXACT, FC_BUS_INEX,
    FC_COPROC, FC_BAD_OPCODE_FLAG, FC_BAD_ISA, FC_BAD_CONT, FC_BAD_RET, FC_MISALIGNED_ACCESS_FLAG, FC_ZERO_DIVISOR_FLAG};
  localparam logic [3:0] BT[18] = '{HB_VECTOR_READ_ERROR_FLAG, PB_FETCH, PB_FETCH, PB_DATA, PB_PUSH, PB_POP,
    BB_PUSH, BB_POP, BB_PREF, BB_EXACT, BB_INEXACT, UB_COPROC, UB_BAD_OPCODE_FLAG, UB_STATE,
    UB_STATE, UB_RET, UB_MISALIGNED_ACCESS_FLAG, UB_ZERO_DIVISOR_FLAG};
  localparam logic [7:0] EN[4] = '{EXC_HARD, EXC_MEM, EXC_BUS, EXC_USAGE};

  fcel_fault_unit fcel_fault_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_cause(fault_cause), .fault_addr(fault_addr),
    .fault_addr_ok(fault_addr_ok), .bus_entry_push(bus_entry_push), .cur_exc(cur_exc),
    .exc_pri(exc_pri), .nmi_req(nmi_req), .exc_take(exc_take), .exc_num(exc_num),
    .lockup(lockup));
  fcel_core_model fcel_core_model_inst (.pclk(pclk), .fault_cause(fault_cause),
    .fault_addr(fault_addr), .fault_addr_ok(fault_addr_ok), .bus_entry_push(bus_entry_push));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Waits a bounded time for the take; n of zero means none may come
  task automatic ev(input fcel_cause_t c, input logic [31:0] ad, input logic ok, bp,
                    input logic [7:0] n);
    int t;
    fcel_core_model_inst.fire(c, ad, ok, bp);
    t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while (exc_take !== 1'b1 && t < 8);
    if (n !== 8'h00) chk({exc_take, exc_num}, {1'b1, n});
    else chk(exc_take, 1'b0);
    repeat (3) @(posedge pclk);
  endtask
  task automatic cmp_all();
    for (int j = 0; j < 4; j++) begin
      apb(1'b0, 8'(4 * j), 32'h0);
      chk(rd, exp_c[j]);
    end
  endtask
  task automatic nmi();
    @(posedge pclk);
    nmi_req <= 1'b1;
    @(posedge pclk);
    nmi_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task results();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, nmi_req, presetn} = 5'h00;
    {paddr, cur_exc, exc_pri, pwdata} = 56'h0;
    {fails, compares, cyc} = 96'h0;
    exp_c = '{0, 0, 0, 0};
    void'($urandom(32'hF5B96077));
    rst();
    for (int j = 0; j < 9; j++) begin
      apb(1'b0, 8'(4 * j), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, OFF_PRI, 32'h00030201);
    apb(1'b1, OFF_CTRL, 32'h7);
    apb(1'b0, OFF_PRI, 32'h0);
    chk(rd, 32'h00030201);
    for (int i = 0; i < 18; i++) begin
      k = (i == 0) ? 0 : (i < 6) ? 1 : (i < 11) ? 2 : 3;
      ev(CS[i], 32'h0, 1'b0, 1'b0, EN[k]);
      exp_c[k] |= 32'h1 << BT[i];
    end
    cmp_all();
    for (int j = 0; j < 4; j++) apb(1'b1, 8'(4 * j), 32'hFFFFFFFF);
    exp_c = '{0, 0, 0, 0};
    cmp_all();
    apb(1'b1, OFF_CTRL, 32'h0);
    ev(FC_BUS_PUSH, 32'h0, 1'b0, 1'b1, 8'h00);
    exp_c[2] |= 32'h1 << BB_PUSH;
    ev(FC_BAD_OPCODE_FLAG, 32'h0, 1'b0, 1'b0, EXC_HARD);
    exp_c[0] |= 32'h1 << HB_ESC;
    exp_c[3] |= 32'h1 << UB_BAD_OPCODE_FLAG;
    apb(1'b1, OFF_CTRL, 32'h7);
    cur_exc <= 8'h10;
    ev(FC_ZERO_DIVISOR_FLAG, 32'h0, 1'b0, 1'b0, EXC_HARD);
    cur_exc <= EXC_USAGE;
    ev(FC_MISALIGNED_ACCESS_FLAG, 32'h0, 1'b0, 1'b0, EXC_HARD);
    exp_c[3] |= (32'h1 << UB_ZERO_DIVISOR_FLAG) | (32'h1 << UB_MISALIGNED_ACCESS_FLAG);
    cur_exc <= EXC_NONE;
    ev(FC_BAD_BRAN, 32'h0, 1'b0, 1'b0, EXC_USAGE);
    exp_c[3] |= 32'h1 << UB_STATE;
    a = $urandom;
    ev(FC_MPU_DATA, a, 1'b1, 1'b0, EXC_MEM);
    apb(1'b0, OFF_PADDR, 32'h0);
    chk(rd, a);
    a = $urandom;
    ev(FC_BUS_EXACT, a, 1'b1, 1'b0, EXC_BUS);
    apb(1'b0, OFF_BADDR, 32'h0);
    chk(rd, a);
    exp_c[1] |= (32'h1 << PB_DATA) | (32'h1 << AB_VALID);
    exp_c[2] |= (32'h1 << BB_EXACT) | (32'h1 << AB_VALID);
    cmp_all();
    cur_exc <= EXC_HARD;
    ev(FC_VEC_RD, 32'h0, 1'b0, 1'b0, 8'h00);
    chk(lockup, 1'b1);
    nmi();
    chk(lockup, 1'b0);
    cur_exc <= EXC_NMI;
    ev(FC_VEC_RD, 32'h0, 1'b0, 1'b0, 8'h00);
    chk(lockup, 1'b1);
    nmi();
    chk(lockup, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h00000103);
    rst();
    @(negedge pclk);
    chk(lockup, 1'b0);
    results();
  end
endmodule
